// File: logic/line_activation_signal_generator.sv
/*
  Line-terminal activation signal generator: wake-up tone, first, second and
  final activation patterns, payload hold until transparency or loopback, register port.
  Assumes symbol_tick, payload and overhead inputs and the far-end indicator
  come from logic on clk_sys; overhead bits arrive already built for service.
*/
// The address-and-strobe port and the address map were left to the implementer.
// Notes on behaviour
// [R1] Tone: four +3, four -3, no sync
// [R2] Missing inverted word: send ordinary sync word
// [R3] Normal overhead: pass service overhead bits through
// [R4] Hold payload until both indicators show transparency (code also opens it on loopback)
// [R5] Final pattern before transparency: line payload zero (code sends payload on loopback)
// [R6] Final pattern runs until turn-off (code also leaves it at a frame boundary on a tone or pattern command)
// [R7] First pattern: ordinary sync, all ones
// [R8] Sequencer advances only at frame boundaries (code leaves the off state at once)
`timescale 1ns/100ps
module line_activation_signal_generator #(
  parameter int FRAME_SYMBOLS = 120,
  parameter int SYNC_SYMBOLS = 9,
  parameter int OVH_SYMBOLS = 3,
  parameter int SUPERFRAME = 8,
  parameter logic [2*SYNC_SYMBOLS-1:0] SYNC_WORD = '0
) (
  input wire logic clk_sys, // System clock, 25 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic ce, // Clock enable, freezes all state when low.
  input wire logic [act_seq_pkg::ADDR_W-1:0] addr, // Register byte address.
  input wire logic [act_seq_pkg::DATA_W-1:0] wr_data, // Register write data.
  input wire logic wr_stb, // Register write strobe.
  input wire logic rd_stb, // Register read strobe.
  output logic [act_seq_pkg::DATA_W-1:0] rd_data, // Read data, cycle after rd_stb.
  input wire logic symbol_tick, // One pulse per line symbol.
  input wire logic [1:0] payload_bits, // Payload bit pair for this symbol.
  input wire logic [1:0] overhead_bits, // Service overhead bit pair.
  input wire logic far_act, // Far-end activation indicator.
  output logic [1:0] symbol_out, // Quaternary symbol as bit pair.
  output logic symbol_valid, // Pulse with each new symbol.
  output logic tx_on // Transmitter turned on.
);
  localparam int POS_W = $clog2(FRAME_SYMBOLS);
  localparam int IDX_W = (SUPERFRAME > 1) ? $clog2(SUPERFRAME) : 1;
  localparam logic [POS_W-1:0] POS_SYNC_END = POS_W'(SYNC_SYMBOLS);
  localparam logic [POS_W-1:0] POS_OVH_START = POS_W'(FRAME_SYMBOLS - OVH_SYMBOLS);
  localparam logic [IDX_W-1:0] IDX_MARKED = '0;

  typedef struct packed {
    act_seq_pkg::seq_state_e state;
    act_seq_pkg::seq_state_e pending;
    logic pending_valid;
    logic [act_seq_pkg::TONE_W-1:0] tone_phase;
    logic loopback;
    logic local_act;
    logic transparent;
    logic [1:0] symbol;
    logic symbol_valid;
    logic tx_on;
    logic [act_seq_pkg::DATA_W-1:0] rd_data;
  } gen_s;

  gen_s s;
  gen_s next_s;

  frame_timing_if #(.POS_W(POS_W), .IDX_W(IDX_W)) tm ();

  frame_timer #(
    .FRAME_SYMBOLS(FRAME_SYMBOLS),
    .SUPERFRAME(SUPERFRAME),
    .POS_W(POS_W),
    .IDX_W(IDX_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .tm(tm)
  );

  assign tm.tick = symbol_tick;
  // Frames only run while a signal is on the line, so the tone starts a frame.
  assign tm.restart = (s.state == act_seq_pkg::transmitter_off);

  assign rd_data = s.rd_data;
  assign symbol_out = s.symbol;
  assign symbol_valid = s.symbol_valid;
  assign tx_on = s.tx_on;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [1:0] sync_symbol(input logic [POS_W-1:0] pos,
                                             input logic invert);
    logic [1:0] sym;
    sym = SYNC_WORD[2*(SYNC_SYMBOLS-1-int'(pos)) +: 2];
    if (invert) begin
      sym[act_seq_pkg::SYM_SIGN] = ~sym[act_seq_pkg::SYM_SIGN];
    end
    return sym;
  endfunction

  function automatic logic is_frame_state(input act_seq_pkg::seq_state_e st);
    return (st == act_seq_pkg::line_pattern_one) || (st == act_seq_pkg::line_pattern_two) ||
           (st == act_seq_pkg::line_pattern_three);
  endfunction

  // Symbol for one position of a framed pattern; the tone is built apart.
  function automatic logic [1:0] frame_symbol(input act_seq_pkg::seq_state_e st,
                                              input logic [POS_W-1:0] pos,
                                              input logic [IDX_W-1:0] idx,
                                              input logic pass,
                                              input logic [1:0] ovh,
                                              input logic [1:0] pay);
    logic [1:0] sym;
    if (pos < POS_SYNC_END) begin
      // The inverted word marks the superframe only where it is present.
      sym = sync_symbol(pos, (idx == IDX_MARKED) && // [R2]
          (st != act_seq_pkg::line_pattern_one)); // [R7]
    end else if (st == act_seq_pkg::line_pattern_one) begin
      sym = act_seq_pkg::BITS_ALL_ONE; // [R7]
    end else if (pos >= POS_OVH_START) begin
      sym = ovh; // [R3]
    end else if (st == act_seq_pkg::line_pattern_three && pass) begin
      sym = pay; // [R4]
    end else begin
      // Payload keeps the pattern-two level until it may open.
      sym = act_seq_pkg::BITS_ALL_ZERO; // [R5]
    end
    return sym;
  endfunction

  // Status is rebuilt on each read. The far indicator is shown live, ahead of the
  // registered transparency bit, so software can tell which end still holds back.
  function automatic logic [act_seq_pkg::DATA_W-1:0] status_word(
      input act_seq_pkg::seq_state_e st,
      input logic transp,
      input logic pend,
      input logic far,
      input logic on);
    logic [act_seq_pkg::DATA_W-1:0] w;
    w = act_seq_pkg::RD_IDLE;
    w[act_seq_pkg::STAT_STATE_LSB +: act_seq_pkg::STAT_STATE_W] = st;
    w[act_seq_pkg::STAT_TRANSPARENT] = transp;
    w[act_seq_pkg::STAT_PENDING] = pend;
    w[act_seq_pkg::STAT_FAR_ACT] = far;
    w[act_seq_pkg::STAT_TX_ON] = on;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    act_seq_pkg::seq_state_e req;
    logic req_valid;
    req = act_seq_pkg::transmitter_off;
    req_valid = 1'b0;
    next_s = s;
    next_s.symbol_valid = 1'b0;
    next_s.rd_data = act_seq_pkg::RD_IDLE;
    next_s.transparent = s.local_act & far_act; // [R4]
    next_s.tx_on = (s.state != act_seq_pkg::transmitter_off);

    if (symbol_tick && s.state != act_seq_pkg::transmitter_off) begin
      next_s.symbol_valid = 1'b1;
      next_s.tone_phase = s.tone_phase + act_seq_pkg::TONE_STEP;
      if (s.state == act_seq_pkg::line_wakeup_tone) begin
        next_s.symbol = (s.tone_phase < act_seq_pkg::TONE_HALF) ? // [R1]
            act_seq_pkg::SYM_PLUS3 : act_seq_pkg::SYM_MINUS3;
      end else begin
        next_s.symbol = frame_symbol(s.state, tm.symbol_pos, tm.frame_idx,
                                     s.transparent || s.loopback, overhead_bits,
                                     payload_bits); // [R4]
      end
    end

    // Changes take effect after the last symbol of a frame; leaving the off
    // state happens at once because no frame is running then.
    if (s.pending_valid) begin
      if (s.state == act_seq_pkg::transmitter_off ||
          (symbol_tick && tm.frame_last && (is_frame_state(s.state) ||
           s.state == act_seq_pkg::line_wakeup_tone))) begin // [R8]
        next_s.state = s.pending;
        next_s.pending_valid = 1'b0;
        next_s.tone_phase = act_seq_pkg::TONE_RESET;
      end
    end

    if (wr_stb) begin
      if (addr == act_seq_pkg::ADDR_CONTROL) begin
        next_s.loopback = wr_data[act_seq_pkg::CTRL_LOOPBACK];
        next_s.local_act = wr_data[act_seq_pkg::CTRL_LOCAL_ACT];
      end else if (addr == act_seq_pkg::ADDR_COMMAND) begin
        // Turn-off outranks any start so the final pattern can always end.
        req_valid = 1'b1;
        if (wr_data[act_seq_pkg::CMD_TURN_OFF]) begin
          req = act_seq_pkg::transmitter_off; // [R6]
        end else if (wr_data[act_seq_pkg::CMD_PATTERN_THREE]) begin
          req = act_seq_pkg::line_pattern_three;
        end else if (wr_data[act_seq_pkg::CMD_PATTERN_TWO]) begin
          req = act_seq_pkg::line_pattern_two;
        end else if (wr_data[act_seq_pkg::CMD_PATTERN_ONE]) begin
          req = act_seq_pkg::line_pattern_one;
        end else if (wr_data[act_seq_pkg::CMD_TONE]) begin
          req = act_seq_pkg::line_wakeup_tone;
        end else begin
          req_valid = 1'b0;
        end
      end
    end
    // A new command wins over the clear at a frame boundary.
    if (req_valid) begin
      next_s.pending = req;
      next_s.pending_valid = 1'b1;
    end

    if (rd_stb) begin
      case (addr)
        act_seq_pkg::ADDR_CONTROL: begin
          next_s.rd_data[act_seq_pkg::CTRL_LOOPBACK] = s.loopback;
          next_s.rd_data[act_seq_pkg::CTRL_LOCAL_ACT] = s.local_act;
        end
        act_seq_pkg::ADDR_STATUS: begin
          next_s.rd_data = status_word(s.state, s.transparent, s.pending_valid, far_act,
                                       s.tx_on);
        end
        default: begin
          next_s.rd_data = act_seq_pkg::RD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // The final pattern has no end of its own: only a new command, turn-off, the tone or another pattern, leaves it at a frame boundary.
  always_ff @(posedge clk_sys) begin // [R6]
    if (reset) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
endmodule

// File: logic/act_seq_pkg.sv
/*
  Shared constants for the line-terminal activation sequencer: register
  offsets and bit positions, quaternary symbol codes, tone shape, reset values.
  Assumes a single clock domain and a plain strobe register port.
*/
package act_seq_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;

  localparam int CTRL_LOOPBACK = 0;
  localparam int CTRL_LOCAL_ACT = 1;

  localparam int CMD_TONE = 0;
  localparam int CMD_PATTERN_ONE = 1;
  localparam int CMD_PATTERN_TWO = 2;
  localparam int CMD_PATTERN_THREE = 3;
  localparam int CMD_TURN_OFF = 4;

  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_STATE_W = 3;
  localparam int STAT_TRANSPARENT = 3;
  localparam int STAT_PENDING = 4;
  localparam int STAT_FAR_ACT = 5;
  localparam int STAT_TX_ON = 6;

  // A symbol is carried as its bit pair: {sign, magnitude}.
  localparam logic [1:0] SYM_PLUS3 = 2'h2;
  localparam logic [1:0] SYM_PLUS1 = 2'h3;
  localparam logic [1:0] SYM_MINUS3 = 2'h0;
  localparam int SYM_SIGN = 1;
  localparam logic [1:0] BITS_ALL_ONE = 2'h3;
  localparam logic [1:0] BITS_ALL_ZERO = 2'h0;

  localparam int TONE_W = 3;
  localparam logic [TONE_W-1:0] TONE_HALF = 3'h4;
  localparam logic [TONE_W-1:0] TONE_STEP = 3'h1;
  localparam logic [TONE_W-1:0] TONE_RESET = 3'h0;

  localparam logic [DATA_W-1:0] RD_IDLE = 32'h0;

  typedef enum logic [2:0] {
    transmitter_off,
    line_wakeup_tone,
    line_pattern_one,
    line_pattern_two,
    line_pattern_three
  } seq_state_e;
endpackage

// File: logic/frame_timing_if.sv
/*
  Carrier between the sequencer and its frame timer: symbol tick, restart,
  position in frame, frame index in superframe and last-symbol flag.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface frame_timing_if #(
  parameter int POS_W = 7,
  parameter int IDX_W = 3
);
  logic tick;
  logic restart;
  logic [POS_W-1:0] symbol_pos;
  logic [IDX_W-1:0] frame_idx;
  logic frame_last;

  modport timer (input tick, input restart, output symbol_pos, output frame_idx,
                 output frame_last);
  modport user (output tick, output restart, input symbol_pos, input frame_idx,
                input frame_last);
endinterface

// File: logic/frame_timer.sv
/*
  Symbol position counter within a frame and frame counter within a
  superframe. Assumes tick is a one-cycle pulse per line symbol.
*/
`timescale 1ns/100ps
module frame_timer #(
  parameter int FRAME_SYMBOLS = 120,
  parameter int SUPERFRAME = 8,
  parameter int POS_W = 7,
  parameter int IDX_W = 3
) (
  input wire logic clk_sys, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic ce, // Clock enable.
  frame_timing_if.timer tm // Timing towards the sequencer.
);
  localparam logic [POS_W-1:0] POS_LAST = POS_W'(FRAME_SYMBOLS - 1);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(SUPERFRAME - 1);
  localparam logic [POS_W-1:0] POS_ONE = POS_W'(1);
  localparam logic [IDX_W-1:0] IDX_ONE = IDX_W'(1);

  typedef struct packed {
    logic [POS_W-1:0] pos;
    logic [IDX_W-1:0] idx;
  } timer_s;

  timer_s s;
  timer_s next_s;

  assign tm.symbol_pos = s.pos;
  assign tm.frame_idx = s.idx;
  assign tm.frame_last = (s.pos == POS_LAST);

  always_comb begin
    next_s = s;
    if (tm.restart) begin
      next_s = '0;
    end else if (tm.tick) begin
      if (s.pos == POS_LAST) begin
        next_s.pos = '0;
        next_s.idx = (s.idx == IDX_LAST) ? '0 : s.idx + IDX_ONE;
      end else begin
        next_s.pos = s.pos + POS_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
endmodule

// File: testbench/act_gen_checker.sv
/* Port checker for the activation generator.
   Assumes it is bound to the top module and that ce drops only while the
   transmitter is off and no read is being answered. */
`timescale 1ns/100ps
module act_gen_checker (
  input wire logic clk_sys, // Clock.
  input wire logic reset, // Reset.
  input wire logic [act_seq_pkg::ADDR_W-1:0] addr, // Address.
  input wire logic wr_stb, // Write strobe.
  input wire logic rd_stb, // Read strobe.
  input wire logic [act_seq_pkg::DATA_W-1:0] rd_data, // Read data.
  input wire logic symbol_tick, // Symbol tick.
  input wire logic far_act, // Far indicator.
  input wire logic [1:0] symbol_out, // Symbol.
  input wire logic symbol_valid, // Symbol pulse.
  input wire logic tx_on // Transmitter on.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_valid_tick: assert property (symbol_valid |-> $past(symbol_tick))
    else $error("symbol without tick");
  a_valid_on: assert property (symbol_valid |-> tx_on)
    else $error("symbol while off");
  a_sym_hold: assert property (!symbol_valid |-> $stable(symbol_out))
    else $error("symbol changed without pulse");
  a_rd_idle: assert property (!$past(rd_stb) |-> rd_data == '0)
    else $error("read data outside answer cycle");
  a_cmd_zero: assert property ($past(rd_stb) && $past(addr) == act_seq_pkg::ADDR_COMMAND
    |-> rd_data == '0) else $error("command read not zero");
  a_unmapped_zero: assert property ($past(rd_stb) && $past(addr) > act_seq_pkg::ADDR_STATUS
    |-> rd_data == '0) else $error("unmapped read not zero");
  a_status_live: assert property ($past(rd_stb) && $past(addr) == act_seq_pkg::ADDR_STATUS
    |-> rd_data[act_seq_pkg::STAT_TX_ON] == $past(tx_on)
    && rd_data[act_seq_pkg::STAT_FAR_ACT] == $past(far_act)) else $error("status bits wrong");
  a_on_cmd: assert property ($rose(tx_on) |-> $past(wr_stb, 3)
    && $past(addr, 3) == act_seq_pkg::ADDR_COMMAND) else $error("start without command");
  a_off_frame: assert property ($fell(tx_on) && !$past(reset) |-> $past(symbol_tick, 2))
    else $error("stop not at a symbol boundary");
endmodule
bind line_activation_signal_generator act_gen_checker chk (.clk_sys, .reset, .addr,
  .wr_stb, .rd_stb, .rd_data, .symbol_tick, .far_act, .symbol_out, .symbol_valid, .tx_on);

// File: testbench/far_end_model.sv
/* Far network terminal: paces line symbols and reports its indicator.
   Assumes one clock shared with the generator. */
`timescale 1ns/100ps
module far_end_model (
  input wire logic clk_sys, // Clock.
  input wire logic reset, // Reset.
  input wire logic report_act, // Bench asks for transparency.
  output logic symbol_tick, // One pulse per symbol.
  output logic far_act // Far indicator.
);
  logic [1:0] div;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div <= 2'h0;
      symbol_tick <= 1'b0;
      far_act <= 1'b0;
    end else begin
      div <= div + 2'h1;
      symbol_tick <= (div == 2'h3);
      // The indicator follows report_act one cycle later, whatever this end shows.
      far_act <= report_act;
    end
  end
endmodule

// File: testbench/line_activation_signal_generator_tb.sv
/* Self-checking bench for the activation generator.
   Assumes the far end model paces symbols every fourth cycle. */
`timescale 1ns/100ps
module line_activation_signal_generator_tb;
  localparam int FS = 16;
  logic clk_sys, reset, wr_stb, rd_stb, symbol_tick, far_act, symbol_valid, tx_on, report_act;
  logic ce;
  logic [3:0] addr;
  logic [31:0] wr_data, rd_data;
  logic [1:0] payload_bits, overhead_bits, symbol_out;
  logic [1:0] fr [FS];
  int num_errors, n_tests, rx_pos, rx_frm;
  line_activation_signal_generator #(.FRAME_SYMBOLS(FS), .SYNC_SYMBOLS(2), .OVH_SYMBOLS(1),
    .SUPERFRAME(2), .SYNC_WORD(4'h9)) dut (.clk_sys, .reset, .ce, .addr, .wr_data,
    .wr_stb, .rd_stb, .rd_data, .symbol_tick, .payload_bits, .overhead_bits, .far_act,
    .symbol_out, .symbol_valid, .tx_on);
  far_end_model far (.clk_sys, .reset, .report_act, .symbol_tick, .far_act);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (!tx_on) begin
      rx_pos <= 0;
      rx_frm <= 0;
    end else if (symbol_valid) begin
      rx_pos <= (rx_pos + 1) % FS;
      if (rx_pos == FS - 1) rx_frm <= (rx_frm + 1) % 2;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: register got %h want %h", $time, got, exp);
    end
  endtask
  task chk_sym(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: symbol got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    // One idle edge, so a following write never drives the strobe twice in a step.
    @(posedge clk_sys);
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(negedge clk_sys);
    chk(rd_data & m, e);
    @(posedge clk_sys);
  endtask
  // Captures one whole frame; p 0 is the tone, pass lets payload through.
  task frame_chk(input int p, input logic pass);
    int f;
    logic [1:0] e;
    @(negedge clk_sys);
    while (!(symbol_valid === 1'b1 && rx_pos == 0)) @(negedge clk_sys);
    f = rx_frm;
    for (int i = 0; i < FS; i++) begin
      while (symbol_valid !== 1'b1) @(negedge clk_sys);
      fr[i] = symbol_out;
      @(negedge clk_sys);
    end
    for (int i = 0; i < FS; i++) begin
      if (p == 0) e = (i % 8 < 4) ? 2'h2 : 2'h0;
      else if (i < 2) e = {(i == 0) ^ (p > 1 && f == 0), (i == 1)};
      else if (p == 1) e = 2'h3;
      else if (i == FS - 1) e = overhead_bits;
      else e = pass ? payload_bits : 2'h0;
      chk_sym(fr[i], e);
    end
    @(posedge clk_sys);
  endtask
  task finish_test;
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Register map: control read back, ignored writes, reads of zero.
  task test_registers;
    wr(act_seq_pkg::ADDR_CONTROL, 32'h2);
    rd_chk(act_seq_pkg::ADDR_CONTROL, 32'h3, 32'h2);
    wr(act_seq_pkg::ADDR_STATUS, 32'h7);
    wr(act_seq_pkg::ADDR_COMMAND, 32'h20);
    rd_chk(act_seq_pkg::ADDR_STATUS, 32'h7f, 32'h0);
    rd_chk(act_seq_pkg::ADDR_COMMAND, '1, 32'h0);
    rd_chk(4'hc, '1, 32'h0);
  endtask
  // Tone and patterns; each command after the tone is written just after a frame ends, so the
  // frame that follows must still carry the old signal.
  task test_sequence;
    wr(act_seq_pkg::ADDR_CONTROL, 32'h0);
    wr(act_seq_pkg::ADDR_COMMAND, 32'h1);
    rd_chk(act_seq_pkg::ADDR_STATUS, 32'h7, 32'h1);
    frame_chk(0, 1'b0);
    wr(act_seq_pkg::ADDR_COMMAND, 32'h2);
    frame_chk(0, 1'b0);
    frame_chk(1, 1'b0);
    frame_chk(1, 1'b0);
    wr(act_seq_pkg::ADDR_COMMAND, 32'h6);
    frame_chk(1, 1'b0);
    frame_chk(2, 1'b0);
    frame_chk(2, 1'b0);
    wr(act_seq_pkg::ADDR_COMMAND, 32'h8);
    frame_chk(2, 1'b0);
    frame_chk(3, 1'b0);
  endtask
  // Payload opens only with both indicators, or under loopback.
  task test_transparency;
    report_act <= 1'b1;
    frame_chk(3, 1'b0);
    rd_chk(act_seq_pkg::ADDR_STATUS, 32'h2f, 32'h24);
    wr(act_seq_pkg::ADDR_CONTROL, 32'h2);
    frame_chk(3, 1'b1);
    report_act <= 1'b0;
    wr(act_seq_pkg::ADDR_CONTROL, 32'h1);
    rd_chk(act_seq_pkg::ADDR_STATUS, 32'h47, 32'h44);
    frame_chk(3, 1'b1);
  endtask
  // Turn-off lets the running frame finish, then the line goes quiet.
  task test_turn_off;
    wr(act_seq_pkg::ADDR_COMMAND, 32'h10);
    frame_chk(3, 1'b1);
    @(negedge clk_sys);
    chk({31'h0, tx_on}, 32'h0);
    @(posedge clk_sys);
    rd_chk(act_seq_pkg::ADDR_STATUS, 32'h7, 32'h0);
  endtask
  // A write while the clock enable is low must be lost.
  task test_clock_enable;
    ce <= 1'b0;
    wr(act_seq_pkg::ADDR_CONTROL, 32'h3);
    ce <= 1'b1;
    rd_chk(act_seq_pkg::ADDR_CONTROL, 32'h3, 32'h1);
  endtask
  // The run needs some 16 frames of 64 cycles; this allows about five times that.
  initial begin
    #200000;
    num_errors++;
    finish_test;
  end
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    {addr, wr_data, wr_stb, rd_stb, report_act} = '0;
    payload_bits = 2'h1;
    overhead_bits = 2'h2;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    test_registers;
    test_sequence;
    test_transparency;
    test_turn_off;
    test_clock_enable;
    finish_test;
  end
endmodule
